/* pkg/host_port_regs.svh */
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
// status register field positions
`define STS_OUT_FULL_BIT 0
`define STS_IN_FULL_BIT 1
`define STS_USER_ZERO_BIT 2
`define STS_CMD_DATA_BIT 3
`define STS_USER_LO_BIT 4
`define STS_USER_HI_BIT 7
// reset values
`define STS_RESET 8'h00
`define BUF_RESET 8'h00
// core register port offsets
`define CORE_OUT_BUF_OFS 2'h0
`define CORE_IN_BUF_OFS 2'h1
`define CORE_STATUS_OFS 2'h2
`define CORE_CTRL_OFS 2'h3
// core control register bits
`define CTRL_IRQ_EN_BIT 0
`define CTRL_USER_ZERO_SET_BIT 1
`define CTRL_USER_ZERO_CLR_BIT 2
`define CTRL_USER_ZERO_TGL_BIT 3
`define CTRL_CMD_DATA_CLR_BIT 4
`define CTRL_CMD_DATA_TGL_BIT 5
`define CTRL_USER_BITS_WR_BIT 6
`endif

/* pkg/host_port_pkg.sv */
package host_port_pkg;
  // synchronised host strobes
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic port_select;
  } host_ctl_t;

  // one-cycle host access events, plus wr_cmd, the held port select of the last write
  typedef struct packed {
    logic rd_data;
    logic rd_status;
    logic wr;
    logic wr_cmd;
  } host_evt_t;
endpackage

/* src/strobe_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module strobe_sync
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw pins
  input wire host_ctl_t pins,
  // synchronised controls
  output host_ctl_t ctl
);
  host_ctl_t meta_r;
  host_ctl_t sync_r;

  // pins idle high; reset to the inactive level avoids a false access
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= 4'hf;
      sync_r <= 4'hf;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  assign ctl = sync_r;
endmodule
`default_nettype wire

/* src/access_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module access_decode
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // synchronised controls
  input wire host_ctl_t ctl,
  // trailing-edge events
  output host_evt_t evt,
  // read window
  output logic rd_active,
  output logic rd_status_sel
);
  logic rd_lvl;
  logic wr_lvl;
  logic rd_prev_r;
  logic wr_prev_r;
  logic psel_rd_r;
  logic psel_wr_r;

  // only low strobes with select low count; select high disables all
  assign rd_lvl = ~ctl.sel_n & ~ctl.rd_n;
  assign wr_lvl = ~ctl.sel_n & ~ctl.wr_n;
  assign rd_active = rd_lvl;
  assign rd_status_sel = ctl.port_select;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      psel_rd_r <= 1'b0;
      psel_wr_r <= 1'b0;
    end else begin
      rd_prev_r <= rd_lvl;
      wr_prev_r <= wr_lvl;
      if (rd_lvl) psel_rd_r <= ctl.port_select;
      if (wr_lvl) psel_wr_r <= ctl.port_select;
    end
  end

  // one event per access, on the trailing edge of the strobe; wr_cmd is the latched write select
  assign evt.rd_data = rd_prev_r & ~rd_lvl & ~psel_rd_r;
  assign evt.rd_status = rd_prev_r & ~rd_lvl & psel_rd_r;
  assign evt.wr = wr_prev_r & ~wr_lvl;
  assign evt.wr_cmd = psel_wr_r;
endmodule
`default_nettype wire

/* src/host_bus_buffer_port.sv */
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_regs.svh"
module host_bus_buffer_port
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host bus pins
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_select,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe,
  // core register port
  input wire logic [1:0] core_addr,
  input wire logic [7:0] core_wdata,
  input wire logic core_wr,
  input wire logic core_rd,
  output logic [7:0] core_rdata,
  // core interrupt request
  output logic core_irq
);
  // ****************************************
  // synchronise and decode
  // ****************************************
  host_ctl_t pins;
  host_ctl_t ctl;
  host_evt_t evt;
  logic rd_active;
  logic rd_status_sel;
  logic [7:0] data_meta_r;
  logic [7:0] data_sync_r;

  assign pins = '{sel_n: sel_n, rd_n: rd_n, wr_n: wr_n, port_select: port_select};

  strobe_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pins(pins),
    .ctl(ctl)
  );

  access_decode u_dec (
    .mclk(mclk),
    .rst(rst),
    .ctl(ctl),
    .evt(evt),
    .rd_active(rd_active),
    .rd_status_sel(rd_status_sel)
  );

  // ****************************************
  // buffers and status
  // ****************************************
  logic [7:0] host_in_buffer_r;
  logic [7:0] host_out_buffer_r;
  logic out_full_flag_r;
  logic in_full_flag_r;
  logic user_flag_zero_r;
  logic cmd_data_flag_r;
  logic [3:0] user_bits_r;
  logic irq_en_r;
  logic core_irq_r;
  logic [7:0] status;
  logic wr_lvl;
  logic core_out_wr;
  logic core_in_rd;
  logic core_ctrl_wr;
  logic [7:0] core_rdata_nxt;

  assign status = {user_bits_r, cmd_data_flag_r, user_flag_zero_r,
                   in_full_flag_r, out_full_flag_r};
  assign wr_lvl = ~ctl.sel_n & ~ctl.wr_n;
  assign core_out_wr = core_wr & (core_addr == `CORE_OUT_BUF_OFS);
  assign core_in_rd = core_rd & (core_addr == `CORE_IN_BUF_OFS);
  assign core_ctrl_wr = core_wr & (core_addr == `CORE_CTRL_OFS);

  // data syncs as deep as the strobes, so each load sees data held under the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_meta_r <= `BUF_RESET;
      data_sync_r <= `BUF_RESET;
    end else begin
      data_meta_r <= host_data_lines_i;
      data_sync_r <= data_meta_r;
    end
  end

  // load only while the synced strobe is low; host may change data once it rises
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_in_buffer_r <= `BUF_RESET;
    end else if (wr_lvl) begin
      host_in_buffer_r <= data_sync_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_out_buffer_r <= `BUF_RESET;
    end else if (core_out_wr) begin
      host_out_buffer_r <= core_wdata;
    end
  end

  // core write listed last so it wins over a host data read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_full_flag_r <= 1'b0;
    end else begin
      if (evt.rd_data) out_full_flag_r <= 1'b0;
      if (core_out_wr) out_full_flag_r <= 1'b1;
    end
  end

  // host write sets over a same-cycle core read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_full_flag_r <= 1'b0;
    end else begin
      if (core_in_rd) in_full_flag_r <= 1'b0;
      if (evt.wr) in_full_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      user_flag_zero_r <= 1'b0;
      cmd_data_flag_r <= 1'b0;
      user_bits_r <= 4'h0;
      irq_en_r <= 1'b0;
    end else begin
      if (core_ctrl_wr) begin
        irq_en_r <= core_wdata[`CTRL_IRQ_EN_BIT];
        if (core_wdata[`CTRL_USER_ZERO_SET_BIT]) user_flag_zero_r <= 1'b1;
        else if (core_wdata[`CTRL_USER_ZERO_CLR_BIT]) user_flag_zero_r <= 1'b0;
        else if (core_wdata[`CTRL_USER_ZERO_TGL_BIT]) user_flag_zero_r <= ~user_flag_zero_r;
        if (core_wdata[`CTRL_CMD_DATA_CLR_BIT]) cmd_data_flag_r <= 1'b0;
        else if (core_wdata[`CTRL_CMD_DATA_TGL_BIT]) cmd_data_flag_r <= ~cmd_data_flag_r;
      end
      if (core_wr & (core_addr == `CORE_STATUS_OFS)) begin
        user_bits_r <= core_wdata[`STS_USER_HI_BIT:`STS_USER_LO_BIT];
      end
      // host write overrides a same-cycle core change
      if (evt.wr) cmd_data_flag_r <= evt.wr_cmd;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    core_rdata_nxt = 8'h00;
    unique case (core_addr)
      `CORE_OUT_BUF_OFS: core_rdata_nxt = host_out_buffer_r;
      `CORE_IN_BUF_OFS: core_rdata_nxt = host_in_buffer_r;
      `CORE_STATUS_OFS: core_rdata_nxt = status;
      `CORE_CTRL_OFS: core_rdata_nxt = {7'h00, irq_en_r};
    endcase
  end

  // read data drive follows the synchronised strobe, so it lags the pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_data_lines_o <= 8'h00;
      host_data_lines_oe <= 1'b0;
      core_rdata <= 8'h00;
      core_irq_r <= 1'b0;
    end else begin
      host_data_lines_oe <= rd_active;
      host_data_lines_o <= rd_status_sel ? status : host_out_buffer_r;
      if (core_rd) core_rdata <= core_rdata_nxt;
      core_irq_r <= evt.wr & irq_en_r;
    end
  end

  assign core_irq = core_irq_r;
endmodule
`default_nettype wire

/* tb/host_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// host port checks
// ****
module host_port_sva (
  // watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic core_rd,
  input wire logic [7:0] core_rdata,
  input wire logic host_data_lines_oe,
  input wire logic core_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // two sync flops plus the output register
  a_oe_needs_sel: assert property (host_data_lines_oe |-> !$past(sel_n, 3))
    else $error("bus driven while unselected");
  a_oe_needs_rd: assert property (host_data_lines_oe |-> !$past(rd_n, 3))
    else $error("bus driven without read");
  a_idle_sel: assert property (sel_n [*4] |-> !host_data_lines_oe)
    else $error("bus driven after select left");
  a_read_drives: assert property ($past(!rd_n && !sel_n, 3) |-> host_data_lines_oe)
    else $error("selected read not driven");
  a_irq_pulse: assert property (core_irq |=> !core_irq [*4])
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (core_irq |-> !$past(wr_n, 5) || !$past(wr_n, 6))
    else $error("interrupt without a host write");
  a_rdata_hold: assert property (!core_rd |=> $stable(core_rdata))
    else $error("core read data changed");
  a_reset_quiet: assert property ($past(rst) |-> !host_data_lines_oe && !core_irq)
    else $error("outputs active out of reset");
  c_read: cover property (host_data_lines_oe);
  c_irq: cover property (core_irq);
  c_wr: cover property ($rose(wr_n) && !sel_n);
endmodule
bind host_bus_buffer_port host_port_sva i_host_port_sva (.mclk, .rst, .sel_n, .rd_n, .wr_n,
  .core_rd, .core_rdata, .host_data_lines_oe, .core_irq);
`default_nettype wire

/* tb/host_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bus master model
// ****
module host_master (
  // clock
  input wire logic mclk,
  // bus pins
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_select,
  output logic [7:0] host_d,
  input wire logic [7:0] bus
);
  initial begin
    {sel_n, rd_n, wr_n, port_select, host_d} = {3'h7, 9'h000};
  end
  // six cycles low and high, double the minimum, so slow flags settle
  task automatic access(input logic cs, a, wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    sel_n <= cs;
    port_select <= a;
    host_d <= d;
    rd_n <= wr;
    wr_n <= !wr;
    repeat (6) @(posedge mclk);
    q = bus;
    {sel_n, rd_n, wr_n} <= 3'h7;
    host_d <= ~d; // released lines show a changed value
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* tb/test_host_bus_buffer_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "host_port_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
// ****
// bench top
// ****
module test_host_bus_buffer_port;
  logic mclk = 0, rst = 1, core_wr = 0, core_rd = 0, oe, core_irq;
  logic sel_n, rd_n, wr_n, port_select;
  logic [1:0] core_addr = 2'h0;
  logic [7:0] core_wdata = 8'h00, core_rdata, o, host_d, q;
  wire logic [7:0] bus = oe ? o : host_d;
  int n_errors = 0, cmp_count = 0, n_irq = 0;
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (core_irq) n_irq <= n_irq + 1;
  host_master i_host_master (.mclk, .sel_n, .rd_n, .wr_n, .port_select, .host_d, .bus);
  host_bus_buffer_port i_host_bus_buffer_port (.mclk, .rst, .sel_n, .rd_n, .wr_n,
    .port_select, .host_data_lines_i(bus), .host_data_lines_o(o), .host_data_lines_oe(oe),
    .core_addr, .core_wdata, .core_wr, .core_rd, .core_rdata, .core_irq);
  task automatic cwr(input logic [1:0] a, input logic [7:0] d);
    core_addr <= a;
    core_wdata <= d;
    core_wr <= 1'b1;
    @(posedge mclk);
    core_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic crd(input logic [1:0] a, input logic [7:0] e);
    core_addr <= a;
    core_rd <= 1'b1;
    @(posedge mclk);
    core_rd <= 1'b0;
    @(posedge mclk);
    `CHK(core_rdata, e)
  endtask
  task automatic t_out;
    cwr(`CORE_OUT_BUF_OFS, 8'ha5);
    i_host_master.access(0, 1, 0, 8'h00, q);
    `CHK(q, 8'h01)
    i_host_master.access(0, 1, 0, 8'h00, q);
    `CHK(q, 8'h01)
    i_host_master.access(0, 0, 0, 8'h00, q);
    `CHK(q, 8'ha5)
    crd(`CORE_STATUS_OFS, 8'h00);
    $display("t_out done");
  endtask
  task automatic t_in;
    cwr(`CORE_CTRL_OFS, 8'h01);
    i_host_master.access(0, 1, 1, 8'h3c, q);
    crd(`CORE_STATUS_OFS, 8'h0a);
    `CHK(n_irq, 1)
    crd(`CORE_IN_BUF_OFS, 8'h3c);
    crd(`CORE_STATUS_OFS, 8'h08);
    cwr(`CORE_CTRL_OFS, 8'h00);
    i_host_master.access(0, 0, 1, 8'hc3, q);
    crd(`CORE_STATUS_OFS, 8'h02);
    `CHK(n_irq, 1)
    $display("t_in done");
  endtask
  task automatic t_sel;
    cwr(`CORE_OUT_BUF_OFS, 8'h96);
    cwr(`CORE_STATUS_OFS, 8'hf0);
    cwr(`CORE_CTRL_OFS, 8'h02);
    i_host_master.access(1, 0, 0, 8'h5a, q);
    `CHK(q, 8'h5a)
    i_host_master.access(1, 1, 1, 8'hff, q);
    crd(`CORE_STATUS_OFS, 8'hf7);
    crd(`CORE_IN_BUF_OFS, 8'hc3);
    $display("t_sel done");
  endtask
  task automatic t_flags;
    cwr(`CORE_CTRL_OFS, 8'h28);
    crd(`CORE_STATUS_OFS, 8'hf9);
    cwr(`CORE_CTRL_OFS, 8'h0a);
    crd(`CORE_STATUS_OFS, 8'hfd);
    cwr(`CORE_CTRL_OFS, 8'h14);
    crd(`CORE_STATUS_OFS, 8'hf1);
    $display("t_flags done");
  endtask
  // core access lands on the edge of the host trailing-edge event
  task automatic t_race;
    fork
      i_host_master.access(0, 0, 0, 8'h00, q);
      begin
        repeat (9) @(posedge mclk);
        cwr(`CORE_OUT_BUF_OFS, 8'h22);
      end
    join
    `CHK(q, 8'h96)
    crd(`CORE_STATUS_OFS, 8'hf1);
    crd(`CORE_OUT_BUF_OFS, 8'h22);
    cwr(`CORE_CTRL_OFS, 8'h01);
    fork
      i_host_master.access(0, 1, 1, 8'h7e, q);
      begin
        repeat (9) @(posedge mclk);
        crd(`CORE_IN_BUF_OFS, 8'h7e);
      end
    join
    crd(`CORE_STATUS_OFS, 8'hfb);
    `CHK(n_irq, 2)
    $display("t_race done");
  endtask
  task automatic t_reset;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    crd(`CORE_STATUS_OFS, 8'h00);
    crd(`CORE_CTRL_OFS, 8'h00);
    $display("t_reset done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    crd(`CORE_STATUS_OFS, 8'h00);
    t_out();
    t_in();
    t_sel();
    t_flags();
    t_race();
    t_reset();
    summarize();
  end
  // tests need about two hundred cycles; this allows some sixty times that
  initial begin
    #100us;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
